//--- src/teg_tap_gate.sv
// Operation
// - With security set, memory reads over the port are refused and return blank.
// - With security set, only full-chip erase passes; other memory commands are blocked.
// - Completed full-chip erase clears security and returns configuration to blank.
// - Each sector has a protect bit; erase of a protected sector is refused.
// - Blank state: memory and logic arrays read as all ones.
// - Blank state: every configuration bit holds zero.
// - Runtime enable bit zero switches the port: zero off, one on.
// - With pins dedicated by configuration, device reset does not disturb port operations.
// - With pins enabled only at runtime, device reset aborts port operations.
// - Port pins active on dedication bit, runtime bit, or select term; else general I/O.
// - Runtime enable register sits at offset C7h from the control block base.
// - Device reset clears the runtime enable bit; software may clear it too.
// - Enabled pins stay inputs until the enable command; only then serial output drives.
`default_nettype none
module teg_tap_gate
   import teg_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire logic         ce,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic              hresp,
   output logic      [31:0]  hrdata,
   input  wire logic         dev_reset,
   input  wire logic         tap_select_product_term,
   input  wire logic [6:0]   portc_in,
   output logic      [6:0]   portc_out,
   output logic      [6:0]   portc_oe_n,
   input  wire logic [6:0]   gpio_out,
   input  wire logic [6:0]   gpio_oe_n,
   output logic      [6:0]   gpio_in,
   output logic              mem_req_valid,
   output teg_mem_req_t      mem_req,
   input  wire logic         mem_done,
   input  wire logic [7:0]   mem_rdata,
   input  wire logic         mem_error,
   input  wire logic         mem_busy
);
   logic [3:0]   sync_q;
   logic [3:0]   sync_rise;
   logic         dev_rst_s;
   logic         mode_s;
   logic         din_s;
   logic         clk_rise;
   logic         tap_on;
   logic         abort;
   logic         busy;
   logic         frame_go;
   teg_op_t      frame_op;

   teg_state_t   state,      next_state;
   teg_nvcfg_t   nv,         next_nv;
   teg_mem_req_t next_req;
   logic         next_req_valid;
   logic         run_en,     next_run_en;
   logic [15:0]  shreg,      next_shreg;
   logic [4:0]   cnt,        next_cnt;
   logic         chan,       next_chan;
   logic         ext_en,     next_ext_en;
   logic         ext_od,     next_ext_od;
   logic         err,        next_err;
   logic [7:0]   outreg,     next_outreg;
   logic         dph_valid,  next_dph_valid;
   logic         dph_write,  next_dph_write;
   logic [11:0]  dph_addr,   next_dph_addr;
   logic [31:0]  next_hrdata;
   logic [6:0]   next_pout;
   logic [6:0]   next_poe_n;

   // Decides whether a memory command may reach the memory controller
   function automatic logic cmd_allowed(input teg_op_t op, input logic [3:0] sector, input teg_nvcfg_t cfg);
      logic ok;
      ok = 1'b1;
      if (cfg.secure)
         ok = (op == OP_CHIP_ERASE);
      else if (op == OP_SECTOR_ERASE)
         ok = (sector < TEG_ALL_SECTORS) && !cfg.protect[sector];
      return ok;
   endfunction

   teg_pin_sync #(.W(4)) u_sync (
      .mclk (mclk),
      .reset(reset),
      .ce   (ce),
      .d    ({dev_reset, portc_in[TEG_PIN_DIN], portc_in[TEG_PIN_CLK], portc_in[TEG_PIN_MODE]}),
      .q    (sync_q),
      .rise (sync_rise)
   );

   assign dev_rst_s = sync_q[3];
   assign din_s     = sync_q[2];
   assign clk_rise  = sync_rise[1];
   assign mode_s    = sync_q[0];
   assign gpio_in   = portc_in;
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign busy      = mem_busy || (state == S_WAIT);
   assign frame_op  = teg_op_t'(shreg[15:12]);

   assign tap_on = nv.dedicate || run_en || tap_select_product_term;
   assign abort  = dev_rst_s && !nv.dedicate;
   assign frame_go = tap_on && !abort && clk_rise && (state == S_IDLE) && !mode_s && (cnt == TEG_FRAME_BITS);

   always_comb
   begin
      next_state     = state;
      next_nv        = nv;
      next_req       = mem_req;
      next_req_valid = 1'b0;
      next_run_en    = run_en;
      next_shreg     = shreg;
      next_cnt       = cnt;
      next_chan      = chan;
      next_ext_en    = ext_en;
      next_ext_od    = ext_od;
      next_err       = err;
      next_outreg    = outreg;
      next_dph_valid = hsel && htrans[1] && hready;
      next_dph_write = hwrite;
      next_dph_addr  = haddr[11:0];
      if (dph_valid && dph_write)
      begin
         if (dph_addr == TEG_ADDR_NVCFG)
            next_nv = hwdata[15:0];
         if (dph_addr == TEG_ADDR_RUN)
            next_run_en = hwdata[TEG_RUN_EN_BIT];
      end
      if (dev_rst_s)
         next_run_en = 1'b0;
      if (dev_rst_s && !chan)
         next_err = 1'b0;
      if (abort || !tap_on)
      begin
         next_state  = S_IDLE;
         next_cnt    = 5'h00;
         next_chan   = 1'b0;
         next_ext_en = 1'b0;
      end
      else
      begin
         if ((state == S_WAIT) && mem_done)
         begin
            next_state = S_IDLE;
            if ((mem_req.op == OP_READ) || (mem_req.op == OP_VERIFY))
               next_outreg = mem_rdata;
            if (mem_error && (mem_req.sector < TEG_FLASH_SECTORS))
               next_err = 1'b1;
            // chip erase returns configuration to blank
            if (mem_req.op == OP_CHIP_ERASE)
               next_nv = TEG_NV_RESET;
         end
         if (clk_rise && (state == S_IDLE))
         begin
            // vacated bits shift in as ones
            next_outreg = {outreg[6:0], 1'b1};
            if (mode_s)
            begin
               next_shreg = {shreg[14:0], din_s};
               if (cnt != TEG_FRAME_BITS)
                  next_cnt = cnt + 5'h01;
            end
            else
               next_cnt = 5'h00;
         end
         if (frame_go)
         begin
            unique case (frame_op)
               OP_NOP: ;
               // serial output opens only on enable command
               OP_ENABLE:
               begin
                  next_chan   = 1'b1;
                  next_ext_en = shreg[TEG_EXT_EN_BIT];
                  next_ext_od = shreg[TEG_EXT_OD_BIT];
               end
               OP_DISABLE:
               begin
                  next_chan   = 1'b0;
                  next_ext_en = 1'b0;
               end
               OP_CLEAR:
                  next_err = 1'b0;
               OP_READ, OP_PROGRAM, OP_VERIFY, OP_SECTOR_ERASE, OP_CHIP_ERASE:
                  if (chan)
                  begin
                     if (cmd_allowed(frame_op, shreg[11:8], nv))
                     begin
                        next_req_valid = 1'b1;
                        next_req       = shreg;
                        next_state     = S_WAIT;
                     end
                     else
                     begin
                        next_err    = 1'b1;
                        next_outreg = TEG_BLANK_BYTE;
                     end
                  end
               default: ;
            endcase
         end
      end
      next_hrdata = hrdata;
      if (next_dph_valid && !hwrite)
      begin
         if (haddr[11:0] == TEG_ADDR_NVCFG)
            next_hrdata = {16'h0000, next_nv};
         else if (haddr[11:0] == TEG_ADDR_RUN)
            next_hrdata = {31'h0000_0000, next_run_en};
         else if (haddr[11:0] == TEG_ADDR_STATUS)
            next_hrdata = {27'h000_0000, busy, err, chan, tap_on, nv.secure};
         else
            next_hrdata = 32'h0000_0000;
      end
   end

   always_comb
   begin
      next_pout  = gpio_out;
      next_poe_n = gpio_oe_n;
      if (tap_on)
      begin
         next_poe_n[TEG_PIN_MODE] = 1'b1;
         next_poe_n[TEG_PIN_CLK]  = 1'b1;
         next_poe_n[TEG_PIN_DIN]  = 1'b1;
         next_poe_n[TEG_PIN_DOUT] = !chan;
         next_pout[TEG_PIN_DOUT]  = outreg[7];
         if (chan && ext_en)
         begin
            next_pout[TEG_PIN_STAT]  = !busy;
            next_poe_n[TEG_PIN_STAT] = ext_od && !busy;
            next_pout[TEG_PIN_ERR]   = !err;
            next_poe_n[TEG_PIN_ERR]  = ext_od && !err;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state         <= S_IDLE;
         nv            <= TEG_NV_RESET;
         mem_req       <= '0;
         mem_req_valid <= 1'b0;
         run_en        <= 1'b0;
         shreg         <= 16'h0000;
         cnt           <= 5'h00;
         chan          <= 1'b0;
         ext_en        <= 1'b0;
         ext_od        <= 1'b0;
         err           <= 1'b0;
         outreg        <= TEG_BLANK_BYTE;
         dph_valid     <= 1'b0;
         dph_write     <= 1'b0;
         dph_addr      <= 12'h000;
         hrdata        <= 32'h0000_0000;
         portc_out     <= 7'h00;
         portc_oe_n    <= 7'h7F;
      end
      else if (ce)
      begin
         state         <= next_state;
         nv            <= next_nv;
         mem_req       <= next_req;
         mem_req_valid <= next_req_valid;
         run_en        <= next_run_en;
         shreg         <= next_shreg;
         cnt           <= next_cnt;
         chan          <= next_chan;
         ext_en        <= next_ext_en;
         ext_od        <= next_ext_od;
         err           <= next_err;
         outreg        <= next_outreg;
         dph_valid     <= next_dph_valid;
         dph_write     <= next_dph_write;
         dph_addr      <= next_dph_addr;
         hrdata        <= next_hrdata;
         portc_out     <= next_pout;
         portc_oe_n    <= next_poe_n;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   read_refused_a: assert property (ce && frame_go && nv.secure && chan && frame_op == OP_READ |=> err && outreg == TEG_BLANK_BYTE && !mem_req_valid) else $error("secured read not refused");
   secure_gate_a: assert property (mem_req_valid |-> $past(!nv.secure) || mem_req.op == OP_CHIP_ERASE) else $error("command passed while secured");
   erase_unsecure_a: assert property (ce && tap_on && !abort && state == S_WAIT && mem_done && mem_req.op == OP_CHIP_ERASE |=> nv == TEG_NV_RESET) else $error("chip erase left configuration set");
   sector_protect_a: assert property (mem_req_valid && mem_req.op == OP_SECTOR_ERASE |-> !$past(nv.protect[shreg[11:8]])) else $error("protected sector erase passed");
   blank_release_a: assert property ($fell(reset) |-> outreg == TEG_BLANK_BYTE && nv == TEG_NV_RESET && !run_en) else $error("not blank after reset");
   run_write_a: assert property (ce && dph_valid && dph_write && dph_addr == TEG_ADDR_RUN && !dev_rst_s |=> run_en == $past(hwdata[0])) else $error("runtime enable write lost");
   run_read_a: assert property (ce && hsel && htrans[1] && hready && !hwrite && haddr[11:0] == TEG_ADDR_RUN |=> hrdata == {31'h0000_0000, run_en}) else $error("runtime enable readback wrong");
   dedicated_hold_a: assert property (ce && nv.dedicate && dev_rst_s && state == S_WAIT && !mem_done |=> state == S_WAIT) else $error("device reset aborted dedicated port");
   runtime_abort_a: assert property (ce && dev_rst_s && !nv.dedicate |=> state == S_IDLE && !chan && !run_en) else $error("device reset did not abort port");
   gpio_pass_a: assert property (ce && !tap_on |=> portc_out == $past(gpio_out) && portc_oe_n == $past(gpio_oe_n)) else $error("pins not released to general I/O");
   dout_quiet_a: assert property (ce && tap_on && !chan |=> portc_oe_n[TEG_PIN_DOUT] && portc_oe_n[TEG_PIN_CLK]) else $error("serial output drove before enable");
endmodule
`default_nettype wire

//--- src/teg_pkg.sv
`default_nettype none
package teg_pkg;
   // Register map, byte addresses within the slave window
   localparam logic [11:0] TEG_ADDR_NVCFG   = 12'h000;
   localparam logic [11:0] TEG_ADDR_STATUS  = 12'h004;
   // Runtime enable register index from the control block base; byte address is four times it
   localparam logic [11:0] TEG_RUN_IDX      = 12'h0C7;
   localparam logic [11:0] TEG_ADDR_RUN     = {TEG_RUN_IDX[9:0], 2'b00};
   localparam int          TEG_RUN_EN_BIT   = 0;

   // Blank delivery state
   localparam logic [15:0] TEG_NV_RESET     = 16'h0000;
   localparam logic [7:0]  TEG_BLANK_BYTE   = 8'hFF;

   // Port C pin positions
   localparam int          TEG_PIN_MODE     = 0;
   localparam int          TEG_PIN_CLK      = 1;
   localparam int          TEG_PIN_STAT     = 3;
   localparam int          TEG_PIN_ERR      = 4;
   localparam int          TEG_PIN_DIN      = 5;
   localparam int          TEG_PIN_DOUT     = 6;

   // Serial frame: opcode[15:12], sector[11:8], data[7:0]
   localparam logic [4:0]  TEG_FRAME_BITS   = 5'h10;
   localparam int          TEG_EXT_EN_BIT   = 0;
   localparam int          TEG_EXT_OD_BIT   = 1;
   localparam logic [3:0]  TEG_FLASH_SECTORS = 4'h8;
   localparam logic [3:0]  TEG_ALL_SECTORS  = 4'hC;

   typedef enum logic [3:0] {
      OP_NOP          = 4'b0000,
      OP_ENABLE       = 4'b0001,
      OP_DISABLE      = 4'b0010,
      OP_CLEAR        = 4'b0011,
      OP_READ         = 4'b0100,
      OP_PROGRAM      = 4'b0101,
      OP_VERIFY       = 4'b0110,
      OP_SECTOR_ERASE = 4'b0111,
      OP_CHIP_ERASE   = 4'b1000
   } teg_op_t;

   typedef enum logic {
      S_IDLE = 1'b0,
      S_WAIT = 1'b1
   } teg_state_t;

   // Nonvolatile configuration: protect[11:8] second memory, protect[7:0] first memory
   typedef struct packed {
      logic [11:0] protect;
      logic [1:0]  unused;
      logic        secure;
      logic        dedicate;
   } teg_nvcfg_t;

   typedef struct packed {
      teg_op_t    op;
      logic [3:0] sector;
      logic [7:0] data;
   } teg_mem_req_t;
endpackage
`default_nettype wire

//--- src/teg_pin_sync.sv
`default_nettype none
module teg_pin_sync
   import teg_pkg::*;
#(
   parameter int W = 4
)
(
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q,
   output logic      [W-1:0] rise
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_s1;
   logic [W-1:0] next_s2;
   logic [W-1:0] next_s3;

   always_comb
   begin
      next_s1 = d;
      next_s2 = s1;
      next_s3 = s2;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end
      else if (ce)
      begin
         s1 <= next_s1;
         s2 <= next_s2;
         s3 <= next_s3;
      end
   end

   assign q    = s2;
   assign rise = s2 & ~s3;
endmodule
`default_nettype wire

//--- dv/teg_tester.sv
`default_nettype none
module teg_tester
(
   output logic mode,
   output logic tck,
   output logic din
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      mode = 1'b0;
      tck = 1'b0;
      din = 1'b0;
   end

   // Test clock stands low between frames; data changes only while it is low
   // pin roles
   task automatic frame(input logic [15:0] f);
      logic [16:0] s;
      s = {f, ~f[0]};
      #13;
      for (int i = 16; i >= 0; i--)
      begin
         mode = (i != 0);
         din = s[16];
         s = s << 1;
         #200 tck = 1'b1;
         #200 tck = 1'b0;
      end
      // Released data line shows the inverse, not a stale bit
      din = ~din;
   endtask
endmodule
`default_nettype wire

//--- dv/teg_tap_gate_test.sv
`default_nettype none
module teg_tap_gate_test
   import teg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic         mclk, reset, hsel, hwrite, hreadyout, hresp, dev_reset, tsel;
   logic         mem_req_valid, mem_done, mode, tck, din;
   logic [31:0]  haddr, hwdata, hrdata, lfsr, rd_got, scratch;
   logic [1:0]   htrans;
   logic [6:0]   gpio_out, gpio_oe_n, gpio_in, portc_out, portc_oe_n, portc_in, gp_d, goe_d;
   logic [7:0]   mem_rdata;
   logic [2:0]   dly;
   teg_mem_req_t mem_req;
   int           num_errors, comparisons;
   logic [31:0]  rd_q[$];
   logic [15:0]  req_q[$];
   event         rd_ev;
   teg_op_t      ops[4] = '{OP_READ, OP_PROGRAM, OP_VERIFY, OP_SECTOR_ERASE};

   // Pin level: the block where it drives, else the tester or a pull-up
   assign portc_in = (portc_out & ~portc_oe_n) | ({1'b1, din, 3'b111, tck, mode} & portc_oe_n);

   teg_tap_gate dut (
      .mclk(mclk), .reset(reset), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .dev_reset(dev_reset), .tap_select_product_term(tsel),
      .portc_in(portc_in), .portc_out(portc_out), .portc_oe_n(portc_oe_n), .gpio_out(gpio_out),
      .gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
      .mem_done(mem_done), .mem_rdata(mem_rdata), .mem_error(1'b0), .mem_busy(1'b0));

   teg_tester u_tester (.mode(mode), .tck(tck), .din(din));

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Random user I/O and a memory controller answering four cycles late
   always @(posedge mclk)
   begin
      lfsr <= next_rand(lfsr);
      gpio_out <= lfsr[6:0];
      gpio_oe_n <= lfsr[13:7];
      mem_rdata <= lfsr[23:16];
      gp_d <= gpio_out;
      goe_d <= gpio_oe_n;
      dly <= {dly[1:0], mem_req_valid};
      mem_done <= dly[2];
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Chip erase targets the whole part, so only its opcode is compared
   task automatic chk_req(input logic [15:0] got, input logic [15:0] exp);
      logic [15:0] m;
      m = (exp[15:12] == OP_CHIP_ERASE) ? 16'hF000 : 16'hFFFF;
      chk({16'h0000, got & m}, {16'h0000, exp & m});
   endtask

   always @(posedge mclk)
      if (mem_req_valid === 1'b1)
         chk_req(mem_req, (req_q.size() != 0) ? req_q.pop_front() : 16'hxxxx);

   always @(rd_ev)
      chk(rd_got, rd_q.pop_front());

   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, scratch);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0000_0000, q);
      rd_q.push_back(e & m);
      rd_got = q & m;
      ->rd_ev;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic send(input teg_op_t op, input logic [3:0] s, input logic [7:0] d, input logic pass);
      if (pass)
         req_q.push_back({op, s, d});
      u_tester.frame({op, s, d});
      idle(20);
   endtask

   task automatic results();
      $display("Errors %0d, comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (9000) @(posedge mclk);
      num_errors++;
      results();
   end

   initial
   begin
      reset = 1'b1;
      {hsel, hwrite, dev_reset, tsel, mem_done} = 5'h00;
      {haddr, hwdata} = 64'h0;
      htrans = 2'b00;
      lfsr = 32'he70b;
      {gpio_out, gpio_oe_n, dly} = 17'h0_0000;
      num_errors = 0;
      comparisons = 0;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rd(TEG_ADDR_NVCFG, 32'h0, 32'hFFFF);
      rd(TEG_ADDR_RUN, 32'h0, 32'hFF);
      rd(32'h0000_0100, 32'h0, 32'hFFFF_FFFF);
      idle(1);
      #1 chk({portc_oe_n[1:0], portc_out[1:0]}, {goe_d[1:0], gp_d[1:0]});
      wr(TEG_ADDR_RUN, 32'h0000_0001);
      rd(TEG_ADDR_RUN, 32'h1, 32'hFF);
      wr(TEG_ADDR_RUN, 32'h0000_0000);
      rd(TEG_ADDR_RUN, 32'h0, 32'hFF);
      wr(TEG_ADDR_RUN, 32'h0000_0001);
      rd(TEG_ADDR_STATUS, 32'h2, 32'h6);
      #1 chk(portc_oe_n & 7'h63, 7'h63);
      send(OP_ENABLE, 4'h0, 8'h01, 1'b0);
      rd(TEG_ADDR_STATUS, 32'h6, 32'h6);
      #1 chk(portc_oe_n[6], 1'b0);
      for (int i = 0; i < 4; i++)
         send(ops[i], 4'h3, lfsr[7:0], 1'b1);
      wr(TEG_ADDR_NVCFG, 32'h0000_0040);
      send(OP_SECTOR_ERASE, 4'h2, 8'h00, 1'b0);
      rd(TEG_ADDR_STATUS, 32'h8, 32'h8);
      #1 chk({portc_oe_n[TEG_PIN_ERR], portc_out[TEG_PIN_ERR], hresp}, 3'b000);
      send(OP_CLEAR, 4'h0, 8'h00, 1'b0);
      rd(TEG_ADDR_STATUS, 32'h0, 32'h8);
      wr(TEG_ADDR_NVCFG, 32'h0000_0042);
      for (int i = 0; i < 4; i++)
         send(ops[i], 4'h3, lfsr[7:0], 1'b0);
      rd(TEG_ADDR_STATUS, 32'h9, 32'h9);
      #1 chk({portc_oe_n[TEG_PIN_DOUT], portc_out[TEG_PIN_DOUT]}, 2'b01);
      send(OP_CLEAR, 4'h0, 8'h00, 1'b0);
      send(OP_CHIP_ERASE, 4'h0, 8'h00, 1'b1);
      rd(TEG_ADDR_NVCFG, 32'h0, 32'hFFFF);
      rd(TEG_ADDR_STATUS, 32'h0, 32'h1);
      dev_reset <= 1'b1;
      idle(3);
      dev_reset <= 1'b0;
      idle(6);
      rd(TEG_ADDR_RUN, 32'h0, 32'hFF);
      rd(TEG_ADDR_STATUS, 32'h0, 32'h6);
      wr(TEG_ADDR_NVCFG, 32'h0000_0001);
      send(OP_ENABLE, 4'h0, 8'h01, 1'b0);
      rd(TEG_ADDR_STATUS, 32'h6, 32'h6);
      dev_reset <= 1'b1;
      send(OP_PROGRAM, 4'h5, lfsr[7:0], 1'b1);
      dev_reset <= 1'b0;
      rd(TEG_ADDR_STATUS, 32'h6, 32'h6);
      wr(TEG_ADDR_NVCFG, 32'h0000_0000);
      rd(TEG_ADDR_STATUS, 32'h0, 32'h2);
      tsel <= 1'b1;
      idle(2);
      rd(TEG_ADDR_STATUS, 32'h2, 32'h2);
      idle(4);
      chk(req_q.size(), 32'h0);
      results();
   end
endmodule
`default_nettype wire
